// >>> bench/tac_master_model.sv
// Purpose: Serial master stand-in driving the write side of the block
// Assumes: Bytes arrive decoded, one pulse each, on the system clock
// Notes: Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module tac_master_model #(
	parameter int BYTE_GAP = 8
) (
	input wire logic clk_sys_in,
	output logic xfer_active_out,
	output logic wr_valid_out,
	output logic wr_first_out,
	output logic [7:0] wr_data_out
);
	initial begin
		xfer_active_out = 1'b0;
		wr_valid_out = 1'b0;
		wr_first_out = 1'b0;
		wr_data_out = 8'h00;
	end
	task automatic put_byte(input logic [7:0] b, input logic first);
		@(posedge clk_sys_in);
		wr_valid_out <= 1'b1;
		wr_first_out <= first;
		wr_data_out <= b;
		@(posedge clk_sys_in);
		wr_valid_out <= 1'b0;
		wr_first_out <= 1'b0;
		wr_data_out <= ~b;
		repeat (BYTE_GAP) @(posedge clk_sys_in);
	endtask : put_byte
	// Write: pointer byte, then data bytes high first; read: no bytes
	task automatic access(input logic wr, input logic [2:0] sel, input int nb,
		input logic [15:0] d);
		@(posedge clk_sys_in);
		xfer_active_out <= 1'b1;
		repeat (BYTE_GAP) @(posedge clk_sys_in);
		if (wr) begin
			put_byte({5'h00, sel}, 1'b1);
			for (int i = 0; i < nb; i++) begin
				put_byte(i[0] ? d[7:0] : d[15:8], 1'b0);
			end
		end else begin
			repeat (3 * BYTE_GAP) @(posedge clk_sys_in);
		end
		xfer_active_out <= 1'b0;
	endtask : access
endmodule : tac_master_model

// >>> bench/temp_adc_conversion_and_pointer_test.sv
// Purpose: Self-checking bench for conversion control and pointer
// Assumes: Shortened auto period; pin idles low between pulses
// Notes: Hold lengths are matched against notes queued by the driver
`timescale 1ns/1ps
module temp_adc_conversion_and_pointer_test;
	localparam int PERIOD = 6000;
	logic clk_sys_in;
	logic rstn_in;
	logic convert_start_n_in;
	logic [9:0] adc_code_in;
	logic xfer, wv, wf, hold, ref_en, busy, valid, is_temp;
	logic hold_prev = 1'b0;
	logic [7:0] wd, ptr, cfg, cfg2;
	logic [15:0] rd, hyst, over_temp_output;
	logic [2:0] chan;
	logic [9:0] codes [3];
	int err_count = 0;
	int n_compared = 0;
	int n_abort = 0;
	int hold_cnt = 0;
	int cyc = 0;
	int n, m;
	int exp_q[$];
	tac_master_model u_tac_master_model (
		.clk_sys_in(clk_sys_in),
		.xfer_active_out(xfer),
		.wr_valid_out(wv),
		.wr_first_out(wf),
		.wr_data_out(wd)
	);
	tac_ctrl_top #(.FULL_VARIANT(1'b1), .AUTO_PERIOD_CYC(PERIOD)) u_tac_ctrl_top (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.convert_start_n_in(convert_start_n_in),
		.xfer_active_in(xfer),
		.wr_valid_in(wv),
		.wr_first_in(wf),
		.wr_data_in(wd),
		.adc_code_in(adc_code_in),
		.rd_data_out(rd),
		.pointer_out(ptr),
		.config_out(cfg),
		.hysteresis_setpoint_out(hyst),
		.over_temp_setpoint_out(over_temp_output),
		.conversion_config_out(cfg2),
		.channel_sel_out(chan),
		.track_hold_out(hold),
		.ref_amp_en_out(ref_en),
		.conv_busy_out(busy),
		.result_valid_out(valid),
		.result_is_temp_out(is_temp)
	);
	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : check
	task automatic in_range(input string what, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi) begin
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
			err_count++;
		end
	endtask : in_range
	task automatic to_hold(output int c);
		c = 0;
		while (hold !== 1'b1 && c < 10000) begin
			@(posedge clk_sys_in);
			c++;
		end
	endtask : to_hold
	// Wait until every noted result is in and the sequencer is idle
	task automatic settle();
		int c;
		c = 0;
		while ((exp_q.size() != 0 || busy !== 1'b0) && c < 4000) begin
			@(posedge clk_sys_in);
			c++;
		end
		in_range("settle cycles", 0, 3999, c);
		repeat (2) @(posedge clk_sys_in);
	endtask : settle
	task automatic wr(input logic [2:0] sel, input int nb, input logic [15:0] d, input int hl);
		exp_q.push_back(hl);
		u_tac_master_model.access(1'b1, sel, nb, d);
		settle();
	endtask : wr
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	// Result monitor
	always @(posedge clk_sys_in) begin
		if (valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				$display("[ERR] result note expected queued seen none");
				err_count++;
			end else begin
				check("hold cycles", 16'(exp_q.pop_front()), 16'(hold_cnt));
			end
		end else if (hold_prev === 1'b1 && hold !== 1'b1) begin
			n_abort++;
		end
		if (ref_en !== hold) check("ref enable", {15'h0, hold}, {15'h0, ref_en});
		hold_prev = hold;
		hold_cnt = (hold === 1'b1) ? hold_cnt + 1 : 0;
	end
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc > 50000) begin
			$display("[ERR] run cycles expected 50000 seen %0d", cyc);
			err_count++;
			close_out();
		end
	end
	initial begin
		rstn_in <= 1'b0;
		convert_start_n_in <= 1'b0;
		adc_code_in <= 10'h000;
		void'($urandom(32'hc784));
		codes = '{10'h200, 10'h1fc, 10'($urandom)};
		repeat (20) @(posedge clk_sys_in);
		check("pointer", 16'h0000, {8'h00, ptr});
		check("config", 16'h0000, {8'h00, cfg});
		check("second config", 16'h0000, {8'h00, cfg2});
		check("setpoints", 16'h0000, hyst | over_temp_output);
		check("read data", 16'h0000, rd);
		check("temp flag", 16'h0001, {15'h0, is_temp});
		rstn_in <= 1'b1;
		exp_q.push_back(1200);
		to_hold(n);
		in_range("reset to hold", 2, 8, n);
		m = cyc;
		settle();
		exp_q.push_back(1200);
		to_hold(n);
		in_range("period to hold", PERIOD - 2, PERIOD + 2, cyc - m);
		settle();
		exp_q.push_back(1200);
		u_tac_master_model.access(1'b1, 3'h2, 2, 16'h4bff);
		to_hold(n);
		in_range("access end to hold", 118, 128, n);
		settle();
		check("hysteresis", 16'h4b80, hyst);
		check("read hysteresis", 16'h4b80, rd);
		foreach (codes[i]) begin
			adc_code_in <= codes[i];
			wr(3'h0, 2, 16'hffff, 1200);
			check("temperature", {codes[i], 6'h00}, rd);
			n = rd[15] ? int'(rd[14:6]) - 512 : int'(rd[14:6]);
			if (i < 2) in_range("degrees C", i ? 127 : -128, i ? 127 : -128, n / 4);
		end
		adc_code_in <= 10'($urandom);
		wr(3'h1, 1, 16'h8000, 600);
		check("config", 16'h0080, {8'h00, cfg});
		check("read config", 16'h8000, rd);
		check("channel", 16'h0004, {13'h0, chan});
		check("temp flag", 16'h0000, {15'h0, is_temp});
		wr(3'h4, 0, 16'h0000, 600);
		check("analog result", {adc_code_in, 6'h00}, rd);
		wr(3'h1, 1, 16'h0000, 1200);
		wr(3'h5, 1, 16'h4000, 1200);
		check("second config", 16'h0040, {8'h00, cfg2});
		wr(3'h3, 2, 16'h1234, 1200);
		check("over-temp setpoint", 16'h1200, over_temp_output);
		exp_q.push_back(1200);
		u_tac_master_model.access(1'b0, 3'h0, 0, 16'h0000);
		settle();
		check("pointer kept", 16'h0003, {8'h00, ptr});
		check("read after read", 16'h1200, rd);
		m = n_abort;
		exp_q.push_back(1200);
		u_tac_master_model.access(1'b0, 3'h0, 0, 16'h0000);
		to_hold(n);
		u_tac_master_model.access(1'b0, 3'h0, 0, 16'h0000);
		settle();
		check("aborts", 16'(m + 1), 16'(n_abort));
		// Pin mode: no start after access, no periodic start
		u_tac_master_model.access(1'b1, 3'h5, 1, 16'h8000);
		repeat (PERIOD + 100) @(posedge clk_sys_in);
		check("pin mode busy", 16'h0000, {15'h0, busy});
		check("second config", 16'h0080, {8'h00, cfg2});
		check("read second config", 16'h8000, rd);
		convert_start_n_in <= 1'b1;
		repeat (200) @(posedge clk_sys_in);
		exp_q.push_back(1200);
		convert_start_n_in <= 1'b0;
		to_hold(n);
		in_range("pin fall to hold", 2, 8, n);
		settle();
		convert_start_n_in <= 1'b1;
		repeat (40) @(posedge clk_sys_in);
		exp_q.push_back(1200);
		convert_start_n_in <= 1'b0;
		to_hold(n);
		in_range("pin rise to hold", 160, 172, n + 40);
		m = n_abort;
		u_tac_master_model.access(1'b0, 3'h0, 0, 16'h0000);
		settle();
		check("pin mode aborts", 16'(m + 1), 16'(n_abort));
		close_out();
	end
endmodule : temp_adc_conversion_and_pointer_test

// >>> verilog/tac_conv_seq.sv
// Purpose: Timed wait, hold, conversion and acquisition sequence
// Assumes: Requests only while idle
// Notes: Runs on the internal clock only
`timescale 1ns/1ps
module tac_conv_seq (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	tac_seq_if.seq sq
);
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_CONV, SEQ_ACQ} tac_seq_state_type;
	tac_seq_state_type state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] len_req, len_cur;
	logic hold_r, hold_nxt, busy_r, busy_nxt, done_r, done_nxt, temp_r, temp_nxt;
	logic [15:0] hold_len_r, hold_len_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		temp_nxt = temp_r;
		done_nxt = 1'b0;
		len_req = sq.temp_sel ? tac_pkg::CONV_TEMP_CYC : tac_pkg::CONV_ANALOG_CYC; // R4
		len_cur = temp_r ? tac_pkg::CONV_TEMP_CYC : tac_pkg::CONV_ANALOG_CYC; // R4
		unique case (state_r)
			SEQ_IDLE: begin
				if (sq.req) begin
					temp_nxt = sq.temp_sel;
					if (sq.wait_cyc == 16'h0000) begin
						state_nxt = SEQ_CONV; // R1
						cnt_nxt = len_req - 16'h0001;
					end else begin
						state_nxt = SEQ_WAIT; // R3
						cnt_nxt = sq.wait_cyc - 16'h0001;
					end
				end
			end
			SEQ_WAIT: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = SEQ_CONV;
					cnt_nxt = len_cur - 16'h0001;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			SEQ_CONV: begin // R8
				if (cnt_r == 16'h0000) begin
					state_nxt = SEQ_ACQ; // R6
					cnt_nxt = tac_pkg::ACQ_CYC - 16'h0001;
					done_nxt = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			SEQ_ACQ: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = SEQ_IDLE;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
		endcase
		if (sq.abort && state_r != SEQ_IDLE) begin
			state_nxt = SEQ_IDLE; // R22
			cnt_nxt = 16'h0000;
			done_nxt = 1'b0;
		end
		hold_nxt = (state_nxt == SEQ_CONV); // R7
		busy_nxt = (state_nxt != SEQ_IDLE);
		hold_len_nxt = hold_r ? hold_len_r + 16'h0001 : 16'h0000;
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= SEQ_IDLE;
			cnt_r <= 16'h0000;
			temp_r <= 1'b0;
			hold_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			hold_len_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			temp_r <= temp_nxt;
			hold_r <= hold_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			hold_len_r <= hold_len_nxt;
		end
	end

	assign sq.hold = hold_r;
	assign sq.ref_en = hold_r;
	assign sq.busy = busy_r;
	assign sq.done = done_r;

	property p_conv_len;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		sq.done |-> hold_len_r == (temp_r ? tac_pkg::CONV_TEMP_CYC : tac_pkg::CONV_ANALOG_CYC);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // R4

	property p_track_after;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		sq.done |-> !sq.hold ##1 !sq.hold [*8];
	endproperty
	a_track_after: assert property (p_track_after) else $error("hold after conversion end"); // R6

	property p_abort_idle;
		@(posedge clk_sys_in) disable iff (!rstn_in)
		(sq.abort && sq.busy) |=> !sq.busy && !sq.hold && !sq.ref_en;
	endproperty
	a_abort_idle: assert property (p_abort_idle) else $error("abort did not stop conversion"); // R22
endmodule : tac_conv_seq

// >>> verilog/tac_ctrl_top.sv
// Purpose: Conversion start, result store and pointer-selected registers
// Assumes: Serial engine on clk_sys_in; convert pin asynchronous
// Notes: Read data follows the pointer one cycle later
`timescale 1ns/1ps
// What this block does
// R1: Falling convert pin edge starts hold, conversion
// R2: Auto mode converts after each serial access
// R3: Hold about 3 us after access end
// R4: Result after 15 us analog, 30 us temperature
// R5: Channel 0 gives a temperature measurement
// R6: Back to track at end; 400 ns acquisition
// R7: Reference amplifier on only during conversion
// R8: Internal clock times conversions, serial clock not
// R9: Temperature is 10-bit two's complement, 0.25 C
// R10: Temperature in top ten bits at 0x00
// R11: Temperature register read-only, low six unused
// R12: First written byte loads the 8-bit pointer
// R13: Only low three pointer bits select registers
// R14: Master writes zeros to pointer bits 3-7
// R15: Codes 0-5 map temp, cfg, hyst, oti, adc, cfg2
// R16: Full variant seven registers, reduced variant five
// R17: Codes span -128 to +127 in two's complement
// R18: Reader divides code by 4, negatives minus 512
// R19: Rising pin powers up; 4 us timer delays start
// R20: Top three config bits choose the channel
// R21: Mode bit clear converts every 355 us
// R22: Serial access aborts conversion, restarts after
// R23: Pointer holds its value across transfers
// R24: Unused temperature bits read as zero
module tac_ctrl_top #(
	parameter bit FULL_VARIANT = 1'b1,
	parameter int unsigned AUTO_PERIOD_CYC = tac_pkg::AUTO_PERIOD_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic convert_start_n_in,
	input wire logic xfer_active_in,
	input wire logic wr_valid_in,
	input wire logic wr_first_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [9:0] adc_code_in,
	output logic [15:0] rd_data_out,
	output logic [7:0] pointer_out,
	output logic [7:0] config_out,
	output logic [15:0] hysteresis_setpoint_out,
	output logic [15:0] over_temp_setpoint_out,
	output logic [7:0] conversion_config_out,
	output logic [2:0] channel_sel_out,
	output logic track_hold_out,
	output logic ref_amp_en_out,
	output logic conv_busy_out,
	output logic result_valid_out,
	output logic result_is_temp_out
);
	tac_seq_if sq ();

	// Pin synchroniser and edge detect
	logic cs_meta_r, cs_sync_r, cs_prev_r, xfer_prev_r;
	logic cs_rise, cs_fall, xfer_rise, xfer_end;

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			// Pin idles low
			cs_meta_r <= 1'b0;
			cs_sync_r <= 1'b0;
			cs_prev_r <= 1'b0;
			xfer_prev_r <= 1'b0;
		end else begin
			cs_meta_r <= convert_start_n_in;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
			xfer_prev_r <= xfer_active_in;
		end
	end

	assign cs_rise = cs_sync_r && !cs_prev_r;
	assign cs_fall = !cs_sync_r && cs_prev_r;
	assign xfer_rise = xfer_active_in && !xfer_prev_r;
	assign xfer_end = !xfer_active_in && xfer_prev_r;

	// Conversion control state
	logic [15:0] pwr_cnt_r, pwr_cnt_nxt;
	logic [31:0] per_cnt_r, per_cnt_nxt;
	logic pend_r, pend_nxt, req_r, req_nxt, abort_r, abort_nxt;
	logic restart_r, restart_nxt, tsel_r, tsel_nxt;
	logic [15:0] pend_wait_r, pend_wait_nxt;
	logic [2:0] chan_r, chan_nxt, chan_cfg;
	logic auto_mode, period_tick, issue;
	logic [7:0] ptr_r, ptr_nxt, cfg_r, cfg_nxt, cfg2_r, cfg2_nxt;

	always_comb begin
		auto_mode = !FULL_VARIANT || !cfg2_r[tac_pkg::CFG2_MODE_BIT]; // R21
		chan_cfg = FULL_VARIANT ? cfg_r[tac_pkg::CFG_CHAN_MSB:tac_pkg::CFG_CHAN_LSB]
			: tac_pkg::CHAN_TEMP; // R20
		if (cs_rise) begin
			pwr_cnt_nxt = tac_pkg::PWRUP_CYC; // R19
		end else if (pwr_cnt_r != 16'h0000) begin
			pwr_cnt_nxt = pwr_cnt_r - 16'h0001;
		end else begin
			pwr_cnt_nxt = pwr_cnt_r;
		end
		period_tick = 1'b0;
		if (xfer_end || !auto_mode) begin
			per_cnt_nxt = 32'(AUTO_PERIOD_CYC - 1); // R2
		end else if (xfer_active_in) begin
			per_cnt_nxt = per_cnt_r;
		end else if (per_cnt_r == 32'h0000_0000) begin
			per_cnt_nxt = 32'(AUTO_PERIOD_CYC - 1);
			period_tick = 1'b1; // R21
		end else begin
			per_cnt_nxt = per_cnt_r - 32'h0000_0001;
		end
		pend_nxt = pend_r;
		pend_wait_nxt = pend_wait_r;
		chan_nxt = chan_r;
		tsel_nxt = tsel_r;
		req_nxt = 1'b0;
		abort_nxt = xfer_rise && (sq.busy || req_r); // R22
		restart_nxt = restart_r;
		if (xfer_end) begin
			restart_nxt = 1'b0;
		end
		if (abort_nxt) begin
			restart_nxt = 1'b1; // R22
		end
		issue = pend_r && !sq.busy && !req_r && !xfer_active_in;
		if (issue) begin
			req_nxt = 1'b1;
			pend_nxt = 1'b0;
			chan_nxt = chan_cfg;
			tsel_nxt = (chan_cfg == tac_pkg::CHAN_TEMP); // R5
		end
		if (cs_fall) begin
			pend_nxt = 1'b1; // R1
			pend_wait_nxt = pwr_cnt_r; // R19
		end else if (xfer_end && (auto_mode || restart_r)) begin
			pend_nxt = 1'b1; // R2
			pend_wait_nxt = tac_pkg::HOLD_DELAY_CYC; // R3
		end else if (period_tick) begin
			pend_nxt = 1'b1;
			pend_wait_nxt = 16'h0000;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pwr_cnt_r <= 16'h0000;
			per_cnt_r <= 32'h0000_0000;
			pend_r <= 1'b0;
			pend_wait_r <= 16'h0000;
			req_r <= 1'b0;
			abort_r <= 1'b0;
			restart_r <= 1'b0;
			chan_r <= tac_pkg::CHAN_TEMP;
			tsel_r <= 1'b1;
		end else begin
			pwr_cnt_r <= pwr_cnt_nxt;
			per_cnt_r <= per_cnt_nxt;
			pend_r <= pend_nxt;
			pend_wait_r <= pend_wait_nxt;
			req_r <= req_nxt;
			abort_r <= abort_nxt;
			restart_r <= restart_nxt;
			chan_r <= chan_nxt;
			tsel_r <= tsel_nxt;
		end
	end

	assign sq.req = req_r;
	assign sq.wait_cyc = pend_wait_r;
	assign sq.temp_sel = tsel_r;
	assign sq.abort = abort_r;

	tac_conv_seq u_seq (
		.clk_sys_in (clk_sys_in),
		.rstn_in (rstn_in),
		.sq (sq)
	);

	// Register file and pointer
	logic [15:0] hyst_r, hyst_nxt, oti_r, oti_nxt, temp_r, temp_nxt, adc_r, adc_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic byte_idx_r, byte_idx_nxt;

	always_comb begin
		ptr_nxt = ptr_r; // R23
		cfg_nxt = cfg_r;
		cfg2_nxt = cfg2_r;
		hyst_nxt = hyst_r;
		oti_nxt = oti_r;
		temp_nxt = temp_r;
		adc_nxt = adc_r;
		byte_idx_nxt = byte_idx_r;
		if (wr_valid_in) begin
			if (wr_first_in) begin
				ptr_nxt = wr_data_in; // R12
				byte_idx_nxt = 1'b0;
			end else begin
				byte_idx_nxt = !byte_idx_r;
				unique case (ptr_r[2:0]) // R13
					tac_pkg::PTR_CFG: cfg_nxt = wr_data_in;
					tac_pkg::PTR_HYST: hyst_nxt = tac_pkg::SETPOINT_MASK & (byte_idx_r ?
						{hyst_r[15:8], wr_data_in} : {wr_data_in, hyst_r[7:0]});
					tac_pkg::PTR_OTI: oti_nxt = tac_pkg::SETPOINT_MASK & (byte_idx_r ?
						{oti_r[15:8], wr_data_in} : {wr_data_in, oti_r[7:0]});
					tac_pkg::PTR_CFG2: begin
						if (FULL_VARIANT) begin
							cfg2_nxt = wr_data_in & tac_pkg::CFG2_MASK; // R16
						end
					end
					default: ; // R11
				endcase
			end
		end
		if (sq.done) begin
			if (tsel_r) begin
				temp_nxt = {adc_code_in, tac_pkg::RESULT_PAD}; // R10 R17 R24
			end else begin
				adc_nxt = {adc_code_in, tac_pkg::RESULT_PAD};
			end
		end
		unique case (ptr_r[2:0]) // R15
			tac_pkg::PTR_TEMP: rd_nxt = temp_r; // R9
			tac_pkg::PTR_CFG: rd_nxt = {cfg_r, 8'h00};
			tac_pkg::PTR_HYST: rd_nxt = hyst_r;
			tac_pkg::PTR_OTI: rd_nxt = oti_r;
			tac_pkg::PTR_ADC: rd_nxt = FULL_VARIANT ? adc_r : 16'h0000; // R16
			tac_pkg::PTR_CFG2: rd_nxt = FULL_VARIANT ? {cfg2_r, 8'h00} : 16'h0000;
			default: rd_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ptr_r <= tac_pkg::PTR_RST;
			cfg_r <= tac_pkg::CFG_RST;
			cfg2_r <= tac_pkg::CFG2_RST;
			hyst_r <= tac_pkg::HYST_RST;
			oti_r <= tac_pkg::OTI_RST;
			temp_r <= tac_pkg::RESULT_RST;
			adc_r <= tac_pkg::RESULT_RST;
			rd_r <= tac_pkg::RESULT_RST;
			byte_idx_r <= 1'b0;
		end else begin
			ptr_r <= ptr_nxt;
			cfg_r <= cfg_nxt;
			cfg2_r <= cfg2_nxt;
			hyst_r <= hyst_nxt;
			oti_r <= oti_nxt;
			temp_r <= temp_nxt;
			adc_r <= adc_nxt;
			rd_r <= rd_nxt;
			byte_idx_r <= byte_idx_nxt;
		end
	end

	assign rd_data_out = rd_r;
	assign pointer_out = ptr_r;
	assign config_out = cfg_r;
	assign hysteresis_setpoint_out = hyst_r;
	assign over_temp_setpoint_out = oti_r;
	assign conversion_config_out = cfg2_r;
	assign channel_sel_out = chan_r;
	assign track_hold_out = sq.hold;
	assign ref_amp_en_out = sq.ref_en;
	assign conv_busy_out = sq.busy;
	assign result_valid_out = sq.done;
	assign result_is_temp_out = tsel_r;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rstn_in);

	property p_pin_fall;
		cs_fall |=> pend_r && pend_wait_r == $past(pwr_cnt_r);
	endproperty
	a_pin_fall: assert property (p_pin_fall) else $error("pin fall not queued"); // R1

	property p_auto_restart;
		(xfer_end && auto_mode && !cs_fall) |=> pend_r && pend_wait_r == tac_pkg::HOLD_DELAY_CYC;
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("no start after access"); // R3

	property p_abort;
		(xfer_rise && sq.busy) |=> abort_r ##1 !sq.busy;
	endproperty
	a_abort: assert property (p_abort) else $error("access did not abort"); // R22

	property p_temp_store;
		(sq.done && tsel_r) |=> temp_r == {$past(adc_code_in), 6'h00};
	endproperty
	a_temp_store: assert property (p_temp_store) else $error("temperature not stored"); // R10

	property p_temp_low_zero;
		temp_r[5:0] == 6'h00 && adc_r[5:0] == 6'h00;
	endproperty
	a_temp_low_zero: assert property (p_temp_low_zero) else $error("low bits not zero"); // R24

	property p_read_sel;
		(ptr_r[2:0] == tac_pkg::PTR_TEMP) |=> rd_data_out == $past(temp_r);
	endproperty
	a_read_sel: assert property (p_read_sel) else $error("wrong register read"); // R13

	property p_powerup;
		cs_rise |=> pwr_cnt_r == tac_pkg::PWRUP_CYC;
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-up timer not loaded"); // R19

	property p_pin_mode;
		!auto_mode |-> !period_tick;
	endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("periodic start in pin mode"); // R21

	property p_ptr_keep;
		!(wr_valid_in && wr_first_in) |=> $stable(ptr_r);
	endproperty
	a_ptr_keep: assert property (p_ptr_keep) else $error("pointer changed"); // R23

	property p_ref_hold;
		($rose(sq.hold) && !sq.abort) |-> sq.ref_en ##1 sq.ref_en;
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("reference not on in conversion"); // R7
endmodule : tac_ctrl_top

// >>> verilog/tac_pkg.sv
// Purpose: Shared constants for the temperature converter control block
// Assumes: 40 MHz system clock
// Notes: Times kept in ns, auto period in us; cycle counts derived from them
package tac_pkg;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned HOLD_DELAY_NS = 3000;
	localparam int unsigned CONV_ANALOG_NS = 15000;
	localparam int unsigned CONV_TEMP_NS = 30000;
	localparam int unsigned ACQ_NS = 400;
	localparam int unsigned PWRUP_NS = 4000;
	localparam int unsigned AUTO_PERIOD_US = 355;
	// Least times, rounded up to whole cycles
	localparam logic [15:0] HOLD_DELAY_CYC = 16'((HOLD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CONV_ANALOG_CYC = 16'((CONV_ANALOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CONV_TEMP_CYC = 16'((CONV_TEMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] ACQ_CYC = 16'((ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] PWRUP_CYC = 16'((PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int unsigned AUTO_PERIOD_CYC = (AUTO_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Register select codes
	localparam logic [2:0] PTR_TEMP = 3'h0;
	localparam logic [2:0] PTR_CFG = 3'h1;
	localparam logic [2:0] PTR_HYST = 3'h2;
	localparam logic [2:0] PTR_OTI = 3'h3;
	localparam logic [2:0] PTR_ADC = 3'h4;
	localparam logic [2:0] PTR_CFG2 = 3'h5;
	// Field positions and masks
	localparam int unsigned CFG_CHAN_MSB = 7;
	localparam int unsigned CFG_CHAN_LSB = 5;
	localparam int unsigned CFG2_MODE_BIT = 7;
	localparam logic [2:0] CHAN_TEMP = 3'h0;
	localparam logic [5:0] RESULT_PAD = 6'h00;
	localparam logic [15:0] SETPOINT_MASK = 16'hff80;
	localparam logic [7:0] CFG2_MASK = 8'hc0;
	// Values after reset
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CFG2_RST = 8'h00;
	localparam logic [15:0] HYST_RST = 16'h0000;
	localparam logic [15:0] OTI_RST = 16'h0000;
	localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage : tac_pkg

// >>> verilog/tac_seq_if.sv
// Purpose: Link between control logic and conversion sequencer
// Assumes: Both ends on clk_sys_in
// Notes: req and abort are one-cycle pulses
`timescale 1ns/1ps
interface tac_seq_if;
	logic req;
	logic [15:0] wait_cyc;
	logic temp_sel;
	logic abort;
	logic busy;
	logic hold;
	logic ref_en;
	logic done;
	modport ctl (output req, output wait_cyc, output temp_sel, output abort,
		input busy, input hold, input ref_en, input done);
	modport seq (input req, input wait_cyc, input temp_sel, input abort,
		output busy, output hold, output ref_en, output done);
endinterface : tac_seq_if
